// File: hw/socket_dma_pkg.sv
// Package: register map, field layout and encodings of the socket DMA configuration.
// Assumes configuration accesses arrive as dword-aligned byte offsets.
package socket_dma_pkg;
    localparam logic [7:0]  REQ_SELECT_OFFSET  = 8'h94;
    localparam logic [7:0]  BASE_CTRL_OFFSET   = 8'h98;
    localparam logic [31:0] REG_RESET          = 32'h0000_0000;

    // Request-select layout
    localparam int          REQ_PIN_LSB        = 0;
    localparam int          REQ_PIN_MSB        = 1;

    // Base and control layout
    localparam int          DECODE_EN_BIT      = 0;
    localparam int          WIDTH_LSB          = 1;
    localparam int          WIDTH_MSB          = 2;
    localparam int          EXT_ADDR_BIT       = 3;
    localparam int          BASE_LSB           = 4;
    localparam int          BASE_MSB           = 15;
    localparam int          BASE_LO_MSB        = 7;
    localparam int          BASE_HI_LSB        = 8;

    // Byte lanes of the configuration write
    localparam int          BE_LOW_LANE        = 0;
    localparam int          BE_HIGH_LANE       = 1;

    typedef enum logic [1:0] {
        PIN_NONE     = 2'b00,
        PIN_SPEAKER  = 2'b01,
        PIN_IO_WIDTH = 2'b10,
        PIN_INPUT_ACK = 2'b11
    } request_pin_e;

    typedef enum logic [1:0] {
        WIDTH_8      = 2'b00,
        WIDTH_16     = 2'b01,
        WIDTH_RSVD_A = 2'b10,
        WIDTH_RSVD_B = 2'b11
    } card_width_e;

    localparam logic [15:0] UPPER_ADDR_ZERO    = 16'h0000;
    localparam logic [3:0]  WINDOW_LOW_ZERO    = 4'h0;
    localparam int          NUM_SOCKETS        = 2;
endpackage

// File: hw/dma_width_pacer.sv
// Splits each prefetched 32-bit PCI dword into card-side units of at most 16 bits.
// Assumes the card side pulses unit_done once per completed card transfer.
`timescale 1ns/1ps
module dma_width_pacer
    import socket_dma_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Prefetch side
    input  wire logic        pf_valid,
    input  wire logic [31:0] pf_data,
    output logic             pf_ready,
    // Configuration
    input  wire logic [1:0]  width_sel,
    // Card side
    output logic             unit_valid,
    output logic [15:0]      unit_data,
    input  wire logic        unit_done
);
    logic [31:0] hold_reg;
    logic [2:0]  left_reg;
    logic        wide_reg;

    // Units per dword: two halves at 16 bits, four bytes at 8 bits
    function automatic logic [2:0] units_for(input logic [1:0] w);
        units_for = (w == WIDTH_16) ? 3'd2 : 3'd4;
    endfunction

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hold_reg <= REG_RESET;
            left_reg <= 3'd0;
            wide_reg <= 1'b0;
        end else if (left_reg == 3'd0) begin
            if (pf_valid) begin
                hold_reg <= pf_data;
                left_reg <= units_for(width_sel);
                wide_reg <= (width_sel == WIDTH_16);
            end
        end else if (unit_done) begin
            // Shift next unit down; never more than 16 bits per card cycle
            hold_reg <= wide_reg ? {16'h0000, hold_reg[31:16]} : {8'h00, hold_reg[31:8]};
            left_reg <= left_reg - 3'd1;
        end
    end

    always_comb begin
        pf_ready   = (left_reg == 3'd0);
        unit_valid = (left_reg != 3'd0);
        unit_data  = wide_reg ? hold_reg[15:0] : {8'h00, hold_reg[7:0]};
    end
endmodule

// File: hw/socket_dma_config.sv
// Socket DMA configuration for both socket functions: request pin select,
// card transfer width, distributed DMA window decode and PCI dword prefetch pacing.
// Assumes a simple single-cycle configuration port per function and synchronous inputs.
`timescale 1ns/1ps
module socket_dma_config
    import socket_dma_pkg::*;
(
    // Clock and global reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Configuration port
    input  wire logic        cfg_func,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_hit,
    // PCI I/O address compare
    input  wire logic        io_valid,
    input  wire logic [31:0] io_addr,
    output logic [1:0]       distributed_dma_hit,
    // Card request pins per socket
    input  wire logic [1:0]  card_speaker_pin,
    input  wire logic [1:0]  card_io_width_pin,
    input  wire logic [1:0]  card_input_ack_pin,
    output logic [1:0]       card_dma_request,
    // Prefetch and card data for socket selected by xfer_sock
    input  wire logic        xfer_sock,
    input  wire logic        pf_valid,
    input  wire logic [31:0] pf_data,
    output logic             pf_ready,
    output logic             unit_valid,
    output logic [15:0]      unit_data,
    output logic             unit_wide,
    input  wire logic        unit_done
);
    logic [1:0]  request_pin_select_reg  [NUM_SOCKETS];
    logic [11:0] distributed_dma_window_base_reg    [NUM_SOCKETS];
    logic [1:0]  card_transfer_width_reg [NUM_SOCKETS];
    logic        distributed_dma_decode_enable_reg  [NUM_SOCKETS];
    logic [31:0] cfg_rdata_next;
    logic        cfg_hit_next;
    logic        pf_ready_w;
    logic        unit_valid_w;
    logic [15:0] unit_data_w;
    logic        pacer_done;
    logic [1:0]  sel_width;
    logic        take_now;
    logic        take_wide_reg;

    function automatic logic [31:0] read_req(input logic [1:0] pin);
        read_req = {30'h0000_0000, pin};
    endfunction

    function automatic logic [31:0] read_base(input logic [11:0] base, input logic [1:0] w, input logic en);
        read_base = {16'h0000, base, 1'b0, w, en};
    endfunction

    // One write decode shared by both registers
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] offset);
        wr_hit = wr && (addr == offset);
    endfunction

    // Pick the requested pin; 00 leaves the socket without DMA
    function automatic logic pick_pin(input logic [1:0] sel, input logic spk, input logic iow, input logic ack);
        case (sel)
            PIN_SPEAKER:   pick_pin = spk;
            PIN_IO_WIDTH:  pick_pin = iow;
            PIN_INPUT_ACK: pick_pin = ack;
            default:       pick_pin = 1'b0;
        endcase
    endfunction

    // Only nrst (global reset) clears these; no soft reset source exists here
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int s = 0; s < NUM_SOCKETS; s++) begin
                request_pin_select_reg[s] <= PIN_NONE;
            end
        end else if (wr_hit(cfg_wr, cfg_addr, REQ_SELECT_OFFSET) && cfg_be[BE_LOW_LANE]) begin
            request_pin_select_reg[cfg_func] <= cfg_wdata[REQ_PIN_MSB:REQ_PIN_LSB];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int s = 0; s < NUM_SOCKETS; s++) begin
                distributed_dma_window_base_reg[s]    <= 12'h000;
                card_transfer_width_reg[s] <= WIDTH_8;
                distributed_dma_decode_enable_reg[s]  <= 1'b0;
            end
        end else if (wr_hit(cfg_wr, cfg_addr, BASE_CTRL_OFFSET)) begin
            // Bit 3 and bits 31-16 have no storage, so writes there vanish
            if (cfg_be[BE_LOW_LANE]) begin
                distributed_dma_window_base_reg[cfg_func][BASE_LO_MSB-BASE_LSB:0] <= cfg_wdata[BASE_LO_MSB:BASE_LSB];
                card_transfer_width_reg[cfg_func]   <= cfg_wdata[WIDTH_MSB:WIDTH_LSB];
                distributed_dma_decode_enable_reg[cfg_func]    <= cfg_wdata[DECODE_EN_BIT];
            end
            if (cfg_be[BE_HIGH_LANE]) begin
                distributed_dma_window_base_reg[cfg_func][BASE_MSB-BASE_LSB:BASE_HI_LSB-BASE_LSB] <=
                    cfg_wdata[BASE_MSB:BASE_HI_LSB];
            end
        end
    end

    always_comb begin
        cfg_rdata_next = REG_RESET;
        cfg_hit_next   = 1'b0;
        if (cfg_rd) begin
            case (cfg_addr)
                REQ_SELECT_OFFSET: begin
                    cfg_rdata_next = read_req(request_pin_select_reg[cfg_func]);
                    cfg_hit_next   = 1'b1;
                end
                BASE_CTRL_OFFSET: begin
                    cfg_rdata_next = read_base(distributed_dma_window_base_reg[cfg_func],
                                               card_transfer_width_reg[cfg_func],
                                               distributed_dma_decode_enable_reg[cfg_func]);
                    cfg_hit_next   = 1'b1;
                end
                default: begin
                    cfg_rdata_next = REG_RESET;
                    cfg_hit_next   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= REG_RESET;
            cfg_hit   <= 1'b0;
        end else begin
            cfg_rdata <= cfg_rdata_next;
            cfg_hit   <= cfg_hit_next;
        end
    end

    // Window compare: upper 16 bits must be zero, low nibble included in the match
    // Both sockets compare every cycle; overlapping windows may hit together
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            distributed_dma_hit <= 2'b00;
        end else begin
            for (int s = 0; s < NUM_SOCKETS; s++) begin
                distributed_dma_hit[s] <= io_valid && distributed_dma_decode_enable_reg[s]
                               && io_addr[31:16] == UPPER_ADDR_ZERO
                               && io_addr[15:0] == {distributed_dma_window_base_reg[s], WINDOW_LOW_ZERO};
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            card_dma_request <= 2'b00;
        end else begin
            // Select 00 parks the request low whatever the card pins do
            for (int s = 0; s < NUM_SOCKETS; s++) begin
                card_dma_request[s] <= pick_pin(request_pin_select_reg[s], card_speaker_pin[s],
                                                card_io_width_pin[s], card_input_ack_pin[s]);
            end
        end
    end

    assign sel_width  = card_transfer_width_reg[xfer_sock];
    // Take only on the registered ready that the far side has already seen
    assign take_now   = pf_valid && pf_ready;
    // Registered outputs lag pacer by a cycle; accept done only on a shown unit
    assign pacer_done = unit_done && unit_valid && unit_valid_w;

    dma_width_pacer u_pacer (
        .mclk       (mclk),
        .nrst       (nrst),
        .pf_valid   (take_now),
        .pf_data    (pf_data),
        .pf_ready   (pf_ready_w),
        .width_sel  (sel_width),
        .unit_valid (unit_valid_w),
        .unit_data  (unit_data_w),
        .unit_done  (pacer_done)
    );

    // Width of the dword in flight, caught at the take so a later change
    // of xfer_sock or of the width field cannot relabel its units
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            take_wide_reg <= 1'b0;
        end else if (take_now) begin
            take_wide_reg <= (sel_width == WIDTH_16);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pf_ready   <= 1'b0;
            unit_valid <= 1'b0;
            unit_data  <= 16'h0000;
            unit_wide  <= 1'b0;
        end else begin
            pf_ready   <= pf_ready_w && !take_now;
            unit_valid <= unit_valid_w && !pacer_done;
            unit_data  <= unit_data_w;
            unit_wide  <= take_wide_reg;
        end
    end
endmodule

// File: bench/socket_dma_sva.sv
// Checker: port-level timing of the socket DMA configuration block.
// Assumes one clock, mclk, and asynchronous active-low nrst.
`timescale 1ns/1ps
module socket_dma_sva (
    input wire logic        mclk, nrst, cfg_rd, cfg_hit, io_valid,
    input wire logic        pf_valid, pf_ready, unit_valid, unit_wide, unit_done,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_rdata, io_addr,
    input wire logic [1:0]  distributed_dma_hit, card_speaker_pin, card_io_width_pin, card_input_ack_pin, card_dma_request,
    input wire logic [15:0] unit_data
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_hit_on_map: assert property (cfg_hit == ($past(cfg_rd) && ($past(cfg_addr) == 8'h94 || $past(cfg_addr) == 8'h98)))
        else $error("cfg_hit mismatch");
    a_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 32'h0)
        else $error("cfg_rdata not zero when idle");
    a_sel_upper_zero: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'h94 |-> cfg_rdata[31:2] == 30'h0)
        else $error("request select upper bits set");
    a_base_upper_zero: assert property (cfg_rdata[31:16] == 16'h0)
        else $error("base control upper bits set");
    a_ext_bit_zero: assert property (cfg_rdata[3] == 1'b0)
        else $error("extended addressing bit set");
    a_window_match: assert property (|distributed_dma_hit |-> $past(io_valid) && ($past(io_addr) & 32'hffff_000f) == 32'h0)
        else $error("window hit outside aligned low window");
    a_byte_unit: assert property (unit_valid && !unit_wide |-> unit_data[15:8] == 8'h00)
        else $error("byte unit with upper data");
    a_unit_holds: assert property (unit_valid && !unit_done |=> unit_valid && $stable(unit_data))
        else $error("unit dropped before done");
    a_take_pace: assert property (pf_valid && pf_ready |=> !pf_ready ##1 unit_valid)
        else $error("prefetch take timing");
    a_req_idle: assert property ($past(card_speaker_pin) == 2'b00 && $past(card_io_width_pin) == 2'b00
        && $past(card_input_ack_pin) == 2'b00 |-> card_dma_request == 2'b00)
        else $error("request without any pin");
endmodule
bind socket_dma_config socket_dma_sva socket_dma_sva_i (.*);

// File: bench/card_side_model.sv
// Card side model: consumes each shown unit after lag cycles.
// Assumes unit_valid holds until unit_done is seen.
`timescale 1ns/1ps
module card_side_model (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       unit_valid,
    input  wire logic [3:0] lag,
    output logic            unit_done
);
    logic [3:0] wait_reg;
    // One-cycle pulse; holding it would swallow the next unit
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_reg  <= 4'h0;
            unit_done <= 1'b0;
        end else if (unit_valid && !unit_done && wait_reg == lag) begin
            wait_reg  <= #1 4'h0;
            unit_done <= #1 1'b1;
        end else begin
            wait_reg  <= #1 (unit_valid && !unit_done) ? wait_reg + 4'h1 : 4'h0;
            unit_done <= #1 1'b0;
        end
    end
endmodule

// File: bench/testbench.sv
// Testbench: configuration reads and writes, window probes, pin routing and unit pacing.
// Assumes the checker is bound to the design and the card model consumes units.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
    import socket_dma_pkg::*;
    logic        mclk = 0, nrst = 0, cfg_func = 0, cfg_wr = 0, cfg_rd = 0, io_valid = 0, xfer_sock = 0, pf_valid = 0;
    logic [7:0]  cfg_addr = 0;
    logic [3:0]  cfg_be = 0, lag = 0;
    logic [31:0] cfg_wdata = 0, io_addr = 0, pf_data = 32'hbeef_cafe, cfg_rdata;
    logic [1:0]  spk = 0, iow = 0, ack = 0, distributed_dma_hit, card_dma_request;
    logic        cfg_hit, pf_ready, unit_valid, unit_wide, unit_done;
    logic [15:0] unit_data;
    int          error_cnt = 0, total_checks = 0, i, j, k;
    always #2.5 mclk = ~mclk;
    socket_dma_config socket_dma_config_i (.mclk, .nrst, .cfg_func, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_hit, .io_valid, .io_addr, .distributed_dma_hit, .card_speaker_pin(spk),
        .card_io_width_pin(iow), .card_input_ack_pin(ack), .card_dma_request, .xfer_sock, .pf_valid,
        .pf_data, .pf_ready, .unit_valid, .unit_data, .unit_wide, .unit_done);
    card_side_model card_side_model_i (.mclk, .nrst, .unit_valid, .lag, .unit_done);
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic lim;
        if (i == 40) begin
            error_cnt++;
            $display("Error wait exp done got timeout");
            stop_test;
        end
    endtask
    task automatic wr(input logic f, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        {cfg_func, cfg_addr, cfg_wdata, cfg_be, cfg_wr} = {f, a, d, b, 1'b1};
        tick;
        cfg_wr = 0;
    endtask
    task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e, input logic h);
        {cfg_func, cfg_addr, cfg_rd} = {f, a, 1'b1};
        tick;
        cfg_rd = 0;
        `CHK("cfg_hit", h, cfg_hit)
        `CHK("cfg_rdata", e, cfg_rdata)
        // Idle edge so a following read never lowers and raises the strobe at once
        tick;
    endtask
    task automatic probe(input logic [31:0] a, input logic [1:0] e);
        {io_addr, io_valid} = {a, 1'b1};
        tick;
        io_valid = 0;
        `CHK("distributed_dma_hit", e, distributed_dma_hit)
        tick;
    endtask
    task automatic push(input logic s);
        {xfer_sock, pf_valid} = {s, 1'b1};
        for (i = 0; i < 40 && pf_ready !== 1'b1; i++) tick;
        lim;
        tick;
        pf_valid = 0;
    endtask
    task automatic unit(input logic [15:0] e, input logic w);
        for (i = 0; i < 40 && unit_valid !== 1'b1; i++) tick;
        lim;
        `CHK("unit_data", e, unit_data)
        `CHK("unit_wide", w, unit_wide)
        for (i = 0; i < 40 && unit_valid === 1'b1; i++) tick;
        lim;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        #1 nrst = 1;
        tick;
        for (j = 0; j < 4; j++) rd(j[1], j[0] ? 8'h98 : 8'h94, 32'h0, 1);
        wr(0, 8'h98, 32'hffff_ffff, 4'hf);
        rd(0, 8'h98, 32'h0000_fff7, 1);
        rd(1, 8'h98, 32'h0, 1);
        wr(1, 8'h94, 32'hffff_ffff, 4'hf);
        rd(1, 8'h94, 32'h3, 1);
        rd(0, 8'h94, 32'h0, 1);
        rd(0, 8'h9c, 32'h0, 0);
        wr(0, 8'h98, 32'h0000_5678, 4'h2);
        rd(0, 8'h98, 32'h0000_56f7, 1);
        wr(0, 8'h98, 32'h0000_1233, 4'h3);
        probe(32'h0000_1230, 2'b01);
        probe(32'h0000_1234, 2'b00);
        probe(32'h0001_1230, 2'b00);
        // Each pin kind raised alone, both sockets at once
        for (j = 0; j < 4; j++) begin
            wr(0, 8'h94, j, 4'h1);
            for (k = 0; k < 3; k++) begin
                {spk, iow, ack} = 6'b110000 >> (2 * k);
                tick;
                `CHK("card_dma_request", {k == 2, j == k + 1}, card_dma_request)
            end
        end
        {spk, iow, ack} = 6'h0;
        lag = 4'h3;
        push(0);
        for (j = 0; j < 2; j++) unit(pf_data[16*j +: 16], 1);
        lag = 4'h0;
        push(1);
        for (j = 0; j < 4; j++) unit({8'h00, pf_data[8*j +: 8]}, 0);
        wr(0, 8'h98, 32'h0000_1232, 4'h1);
        probe(32'h0000_1230, 2'b00);
        nrst = 0;
        tick;
        nrst = 1;
        tick;
        rd(0, 8'h98, 32'h0, 1);
        stop_test;
    end
endmodule
